/* File: design/pxs_defines.vh */
`ifndef PXS_DEFINES_VH
`define PXS_DEFINES_VH

// Bus address.
`define PXS_SLAVE_ADDR 7'h60

// Command codes.
`define PXS_CODE_STANDBY 8'h00
`define PXS_CODE_SAMPLE 8'h03
`define PXS_CODE_FORCE 8'h04
`define PXS_CODE_LOWLIM 8'h05
`define PXS_CODE_HIGHLIM 8'h06
`define PXS_CODE_XTALK 8'h07
`define PXS_CODE_AUTOCAL 8'h08
`define PXS_CODE_RESULT 8'hf8
`define PXS_CODE_FLAGS 8'hf9
`define PXS_CODE_DEVID 8'hfa
`define PXS_CODE_CALRES 8'hfb

// Reset values of the writable words, high byte above low byte.
`define PXS_RST_STANDBY 16'h0001
`define PXS_RST_SAMPLE 16'h0001
`define PXS_RST_ZERO 16'h0000

// Fields of the sample setup low byte.
`define PXS_RUN_STOP_BIT 0
`define PXS_FAST_BIT 1
`define PXS_MODE_LSB 2
`define PXS_REPEAT_LSB 4

// Self-clearing force trigger in the force setup low byte.
`define PXS_FORCE_TRIG_BIT 5

// Interrupt modes.
`define PXS_MODE_OFF 2'h0
`define PXS_MODE_LOGIC 2'h1
`define PXS_MODE_FIRST 2'h2
`define PXS_MODE_FULL 2'h3

// Flag bits in the flag high byte.
`define PXS_FLAG_LOW_BIT 0
`define PXS_FLAG_HIGH_BIT 1

// Calibration result high byte layout.
`define PXS_CAL_BUSY_BIT 6
`define PXS_CAL_SUN_BIT 7

`endif

/* File: design/pxs_sensor_regs.v */
`timescale 1ns/1ps
`include "pxs_defines.vh"

module pxs_sensor_regs
#(
    // Identification word; value is arbitrary.
    parameter [15:0] DEVICE_CODE = 16'h00a5,
    parameter RESULT_WIDTH = 12
)
(
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // Two-wire bus pins.
    input wire sclIn,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    // Interrupt pin, open drain.
    output reg intOut,
    output reg intOe,
    // Measurement front end.
    input wire measValid,
    input wire [RESULT_WIDTH-1:0] measRaw,
    input wire [11:0] calData,
    input wire calBusy,
    input wire calSun,
    // Configuration towards the front end.
    output reg [15:0] standbyWord,
    output reg [15:0] sampleWord,
    output reg [15:0] forceWord,
    output reg [15:0] autocalWord,
    output reg forceTrig,
    output reg fastSampleReq
);

////////////////////////////////////////////////////////////////////////////////

localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_ADDR = 4'h1;
localparam [3:0] ST_CMD = 4'h2;
localparam [3:0] ST_WDATA = 4'h3;
localparam [3:0] ST_ACK = 4'h4;
localparam [3:0] ST_RDATA = 4'h5;
localparam [3:0] ST_MACK = 4'h6;

reg sclPrev;
reg sdaPrev;
reg [3:0] state;
reg [3:0] afterAck;
reg [2:0] bitCnt;
reg byteDone;
reg [7:0] rxShift;
reg [7:0] txShift;
reg [3:0] txCnt;
reg [7:0] cmdCode;
reg [7:0] lowByte;
reg byteHigh;
reg [15:0] lowLimit;
reg [15:0] highLimit;
reg [15:0] crosstalkOffset;
reg [RESULT_WIDTH-1:0] proximityResult;
reg [15:0] autocalResult;
reg [7:0] alertFlags;
reg [2:0] aboveCnt;
reg [2:0] belowCnt;
reg closeState;

wire sclRise = sclIn & ~sclPrev;
wire sclFall = ~sclIn & sclPrev;
wire startCond = sclIn & sclPrev & sdaPrev & ~sdaIn;
wire stopCond = sclIn & sclPrev & ~sdaPrev & sdaIn;

////////////////////////////////////////////////////////////////////////////////

// Byte returned for a command code and half; unmapped codes read zero.
function [7:0] readByte;
    input [7:0] code;
    input high;
    reg [15:0] word;
    begin
        word = 16'h0000;
        case (code)
            `PXS_CODE_STANDBY: word = standbyWord;
            `PXS_CODE_SAMPLE: word = sampleWord;
            `PXS_CODE_FORCE: word = forceWord;
            `PXS_CODE_LOWLIM: word = lowLimit;
            `PXS_CODE_HIGHLIM: word = highLimit;
            `PXS_CODE_XTALK: word = crosstalkOffset;
            `PXS_CODE_AUTOCAL: word = autocalWord;
            `PXS_CODE_RESULT: word = {{(16 - RESULT_WIDTH){1'b0}}, proximityResult};
            `PXS_CODE_FLAGS: word = {alertFlags, 8'h00};
            `PXS_CODE_DEVID: word = DEVICE_CODE;
            `PXS_CODE_CALRES: word = autocalResult;
            default: word = 16'h0000;
        endcase
        readByte = high ? word[15:8] : word[7:0];
    end
endfunction

// Count of consecutive measurements that a persistence field asks for.
function [2:0] repeatNeed;
    input [1:0] field;
    begin
        repeatNeed = {1'b0, field} + 3'h1;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

// Result after crosstalk removal, clamped at zero.
wire [RESULT_WIDTH-1:0] xtalkLevel = crosstalkOffset[RESULT_WIDTH-1:0];
wire [RESULT_WIDTH-1:0] cleanResult = (measRaw > xtalkLevel) ? (measRaw - xtalkLevel) :
    {RESULT_WIDTH{1'b0}};
wire [15:0] cleanWide = {{(16 - RESULT_WIDTH){1'b0}}, cleanResult};
wire measRunning = ~sampleWord[`PXS_RUN_STOP_BIT];
wire [1:0] intMode = sampleWord[`PXS_MODE_LSB +: 2];
wire [2:0] need = repeatNeed(sampleWord[`PXS_REPEAT_LSB +: 2]);
wire fastOn = sampleWord[`PXS_FAST_BIT];
wire wantHigh = (intMode != `PXS_MODE_OFF);
wire wantLow = (intMode == `PXS_MODE_FULL) || (intMode == `PXS_MODE_LOGIC);
wire isAbove = cleanWide > highLimit;
wire isBelow = cleanWide < lowLimit;
wire highEvent = measValid & measRunning & isAbove & (aboveCnt == need - 3'h1);
wire lowEvent = measValid & measRunning & isBelow & (belowCnt == need - 3'h1);

// The host acknowledging the low byte of the flag code is the read that clears the flags.
wire flagsRead = (state == ST_MACK) & sclFall & ~byteHigh & (cmdCode == `PXS_CODE_FLAGS);
// Bytes loaded into the transmitter, so each one is decoded once.
wire [7:0] loadByte = readByte(cmdCode, byteHigh);
wire [7:0] upperByte = readByte(cmdCode, 1'b1);

////////////////////////////////////////////////////////////////////////////////

// Bus edge history.
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        sclPrev <= 1'b1;
        sdaPrev <= 1'b1;
        sdaOut <= 1'b0;
    end
    else
    begin
        sclPrev <= sclIn;
        sdaPrev <= sdaIn;
        sdaOut <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////

// Slave protocol engine and register writes.
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        state <= ST_IDLE;
        afterAck <= ST_IDLE;
        bitCnt <= 3'h0;
        byteDone <= 1'b0;
        rxShift <= 8'h00;
        txShift <= 8'h00;
        txCnt <= 4'h0;
        cmdCode <= 8'h00;
        lowByte <= 8'h00;
        byteHigh <= 1'b0;
        sdaOe <= 1'b0;
        forceTrig <= 1'b0;
        standbyWord <= `PXS_RST_STANDBY;
        sampleWord <= `PXS_RST_SAMPLE;
        forceWord <= `PXS_RST_ZERO;
        lowLimit <= `PXS_RST_ZERO;
        highLimit <= `PXS_RST_ZERO;
        crosstalkOffset <= `PXS_RST_ZERO;
        autocalWord <= `PXS_RST_ZERO;
    end
    else
    begin
        forceTrig <= 1'b0;
        if (startCond)
        begin
            state <= ST_ADDR;
            bitCnt <= 3'h0;
            byteDone <= 1'b0;
            sdaOe <= 1'b0;
        end
        else if (stopCond)
        begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
        end
        else if (sclRise && (state == ST_ADDR || state == ST_CMD || state == ST_WDATA))
        begin
            rxShift <= {rxShift[6:0], sdaIn};
            bitCnt <= bitCnt + 3'h1;
            byteDone <= (bitCnt == 3'h7);
        end
        else if (sclRise && state == ST_MACK)
        begin
            // Host not acknowledging ends the read.
            if (sdaIn)
                state <= ST_IDLE;
        end
        else if (sclFall)
        begin
            case (state)
                ST_ADDR:
                begin
                    if (byteDone)
                    begin
                        byteDone <= 1'b0;
                        if (rxShift[7:1] == `PXS_SLAVE_ADDR)
                        begin
                            sdaOe <= 1'b1;
                            state <= ST_ACK;
                            byteHigh <= 1'b0;
                            afterAck <= rxShift[0] ? ST_RDATA : ST_CMD;
                        end
                        else
                            state <= ST_IDLE;
                    end
                end
                ST_CMD:
                begin
                    if (byteDone)
                    begin
                        byteDone <= 1'b0;
                        cmdCode <= rxShift;
                        sdaOe <= 1'b1;
                        state <= ST_ACK;
                        afterAck <= ST_WDATA;
                    end
                end
                ST_WDATA:
                begin
                    if (byteDone)
                    begin
                        byteDone <= 1'b0;
                        sdaOe <= 1'b1;
                        state <= ST_ACK;
                        if (!byteHigh)
                        begin
                            lowByte <= rxShift;
                            byteHigh <= 1'b1;
                            afterAck <= ST_WDATA;
                        end
                        else
                        begin
                            byteHigh <= 1'b0;
                            afterAck <= ST_IDLE;
                            case (cmdCode)
                                `PXS_CODE_STANDBY: standbyWord <= {rxShift, lowByte};
                                `PXS_CODE_SAMPLE: sampleWord <= {rxShift, lowByte};
                                `PXS_CODE_FORCE:
                                begin
                                    forceWord <= {rxShift, lowByte &
                                        ~(8'h01 << `PXS_FORCE_TRIG_BIT)};
                                    forceTrig <= lowByte[`PXS_FORCE_TRIG_BIT];
                                end
                                `PXS_CODE_LOWLIM: lowLimit <= {rxShift, lowByte};
                                `PXS_CODE_HIGHLIM: highLimit <= {rxShift, lowByte};
                                `PXS_CODE_XTALK: crosstalkOffset <= {rxShift, lowByte};
                                `PXS_CODE_AUTOCAL: autocalWord <= {rxShift, lowByte};
                                default: lowByte <= lowByte;
                            endcase
                        end
                    end
                end
                ST_ACK:
                begin
                    sdaOe <= 1'b0;
                    bitCnt <= 3'h0;
                    state <= afterAck;
                    if (afterAck == ST_RDATA)
                    begin
                        txShift <= {loadByte[6:0], 1'b0};
                        sdaOe <= ~loadByte[7];
                        txCnt <= 4'h1;
                    end
                end
                ST_RDATA:
                begin
                    if (txCnt == 4'h8)
                    begin
                        sdaOe <= 1'b0;
                        state <= ST_MACK;
                    end
                    else
                    begin
                        sdaOe <= ~txShift[7];
                        txShift <= txShift << 1;
                        txCnt <= txCnt + 4'h1;
                    end
                end
                ST_MACK:
                begin
                    if (!byteHigh)
                    begin
                        byteHigh <= 1'b1;
                        txShift <= {upperByte[6:0], 1'b0};
                        sdaOe <= ~upperByte[7];
                        txCnt <= 4'h1;
                        state <= ST_RDATA;
                    end
                    else
                    begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

// Measurement capture, persistence and flag handling.
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        proximityResult <= {RESULT_WIDTH{1'b0}};
        autocalResult <= 16'h0000;
        aboveCnt <= 3'h0;
        belowCnt <= 3'h0;
        alertFlags <= 8'h00;
        closeState <= 1'b0;
        fastSampleReq <= 1'b0;
        intOut <= 1'b0;
        intOe <= 1'b0;
    end
    else
    begin
        fastSampleReq <= 1'b0;
        intOut <= 1'b0;
        autocalResult <= {calSun, calBusy, 2'b00, calData};
        if (measValid && measRunning)
        begin
            proximityResult <= cleanResult;
            aboveCnt <= isAbove ? ((aboveCnt == need) ? need : aboveCnt + 3'h1) : 3'h0;
            belowCnt <= isBelow ? ((belowCnt == need) ? need : belowCnt + 3'h1) : 3'h0;
            fastSampleReq <= fastOn && ((isAbove && aboveCnt < need - 3'h1) ||
                (isBelow && belowCnt < need - 3'h1));
        end
        // Logic mode keeps a close state that upper events set and lower events clear.
        if (intMode == `PXS_MODE_LOGIC)
        begin
            if (highEvent)
                closeState <= 1'b1;
            else if (lowEvent)
                closeState <= 1'b0;
        end
        else
        begin
            closeState <= 1'b0;
        end
        if (flagsRead)
            alertFlags <= 8'h00;
        if (highEvent && wantHigh)
            alertFlags[`PXS_FLAG_HIGH_BIT] <= 1'b1;
        if (lowEvent && wantLow)
            alertFlags[`PXS_FLAG_LOW_BIT] <= 1'b1;
        intOe <= (intMode == `PXS_MODE_LOGIC) ? closeState :
            ((intMode != `PXS_MODE_OFF) && (alertFlags != 8'h00));
    end
end

endmodule

/* File: test/proximity_sensor_i2c_regs_test.sv */
`timescale 1ns/1ps
`include "pxs_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: host model on the bus, measurements driven directly.
module proximity_sensor_i2c_regs_test;
    localparam [15:0] DEV_CODE = 16'h005a; // Arbitrary identification value.
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg measValid = 1'b0;
    reg [11:0] measRaw = 12'h000;
    reg [11:0] calData = 12'h9c3;
    reg calBusy = 1'b1;
    reg calSun = 1'b0;
    reg sawForce = 1'b0;
    reg sawFast = 1'b0;
    wire sclLine, sdaDrive, sdaOut, sdaOe, intOut, intOe, forceTrig, fastSampleReq;
    wire [15:0] standbyWord, sampleWord, forceWord, autocalWord;
    // Pull-up wire: low when either party pulls it down.
    wire sdaLine = sdaDrive & !sdaOe;
    integer failCount = 0;
    integer checks = 0;
    integer i;
    logic [7:0] rcode [0:10] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                 8'hf8, 8'hf9, 8'hfa, 8'hfb};
    logic [15:0] rval [0:10] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
                                 16'h0000, 16'h0000, 16'h0000, 16'h0000, DEV_CODE, 16'h49c3};
    logic [15:0] wval [0:4] = '{16'h5a08, 16'h000a, 16'h0032, 16'h0005, 16'h0112};

    // Clock of 100 ns period.
    always #50 mclk = !mclk;

    // Remembers the one-cycle pulses.
    always @(posedge mclk)
    begin
        if (forceTrig === 1'b1)
            sawForce <= 1'b1;
        if (fastSampleReq === 1'b1)
            sawFast <= 1'b1;
    end

    pxs_host_model u_host (.mclk(mclk), .sclLine(sclLine), .sdaDrive(sdaDrive),
                           .sdaLine(sdaLine));

    pxs_sensor_regs #(.DEVICE_CODE(DEV_CODE)) u_dut
    (
        .mclk(mclk), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe), .measValid(measValid),
        .measRaw(measRaw), .calData(calData), .calBusy(calBusy), .calSun(calSun),
        .standbyWord(standbyWord), .sampleWord(sampleWord), .forceWord(forceWord),
        .autocalWord(autocalWord), .forceTrig(forceTrig), .fastSampleReq(fastSampleReq)
    );

    // Prints the counts and the verdict, then ends the run.
    task reportAndStop;
        begin
            $display("checks %0d mismatches %0d", checks, failCount);
            if (failCount == 0 && checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // Compares one value and counts it.
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        begin
            checks = checks + 1;
            if (got !== exp)
            begin
                failCount = failCount + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // Word write with every byte acknowledged.
    task wr(input logic [7:0] code, input logic [15:0] w);
        logic [3:0] a;
        begin
            u_host.write_word(`PXS_SLAVE_ADDR, code, w, a);
            check($sformatf("write acks %h", code), 16'h000f, {12'h000, a});
        end
    endtask

    // Word read compared with the expected word.
    task rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] w;
        logic [2:0] a;
        begin
            u_host.read_word(code, w, a);
            check($sformatf("read acks %h", code), 16'h0007, {13'h0000, a});
            check($sformatf("code %h", code), exp, w);
        end
    endtask

    // One measurement pulse while the block runs.
    task meas(input logic [11:0] raw);
        begin
            measRaw = raw;
            measValid = 1'b1;
            u_host.tick(1);
            measValid = 1'b0;
            u_host.tick(4);
        end
    endtask

    // Bounded wait for the interrupt pin to be pulled low.
    task waitInt;
        integer n;
        begin
            n = 0;
            while (intOe !== 1'b1 && n < 20)
            begin
                u_host.tick(1);
                n = n + 1;
            end
            check("interrupt", 16'h0001, {15'h0000, intOe});
            if (intOe !== 1'b1)
                reportAndStop;
        end
    endtask

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        u_host.tick(2);
        for (i = 0; i < 11; i = i + 1)
            rd(rcode[i], rval[i]);
        check("sample word", 16'h0001, sampleWord);
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(rcode[i + 2], wval[i]);
            rd(rcode[i + 2], wval[i]);
        end
        check("force word", 16'h5a08, forceWord);
        check("autocal word", 16'h0112, autocalWord);
        wr(8'h00, 16'h0203);
        wr(8'h00, 16'h0283);
        check("standby word", 16'h0283, standbyWord);
        wr(8'hf8, 16'hffff);
        wr(8'hfa, 16'h0000);
        rd(8'hf8, 16'h0000);
        rd(8'hfa, DEV_CODE);
        u_host.write_word(7'h61, 8'h05, 16'hffff, i[3:0]);
        check("foreign acks", 16'h0000, {12'h000, i[3:0]});
        rd(8'h05, 16'h000a);
        wr(8'h04, 16'h5a28);
        check("force pulse", 16'h0001, {15'h0000, sawForce});
        check("force kept", 16'h5a08, forceWord);
        wr(8'h03, 16'h002c);
        meas(12'd100);
        rd(8'hf8, 16'h005f);
        meas(12'd60);
        check("early interrupt", 16'h0000, {15'h0000, intOe});
        meas(12'd60);
        waitInt;
        rd(8'hf9, 16'h0200);
        check("released", 16'h0000, {15'h0000, intOe});
        for (i = 0; i < 3; i = i + 1)
            meas(12'd3);
        waitInt;
        rd(8'hf8, 16'h0000);
        rd(8'hf9, 16'h0100);
        wr(8'h03, 16'h0000);
        meas(12'd60);
        check("disabled", 16'h0000, {15'h0000, intOe});
        wr(8'h03, 16'h0008);
        meas(12'd3);
        check("first high", 16'h0000, {15'h0000, intOe});
        meas(12'd60);
        waitInt;
        rd(8'hf9, 16'h0200);
        wr(8'h03, 16'h003e);
        meas(12'd60);
        check("fast request", 16'h0001, {15'h0000, sawFast});
        wr(8'h03, 16'h0004);
        meas(12'd3);
        meas(12'd60);
        waitInt;
        meas(12'd3);
        check("logic low", 16'h0000, {15'h0000, intOe});
        check("drive levels", 16'h0000, {14'h0000, sdaOut, intOut});
        reportAndStop;
    end
endmodule

/* File: test/pxs_host_model.sv */
`timescale 1ns/1ps
`include "pxs_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Two-wire bus master standing in for the host controller.
module pxs_host_model
(
    // Clock.
    input wire mclk,
    // Bus lines; a released data line is pulled up outside.
    output reg sclLine,
    output reg sdaDrive,
    input wire sdaLine
);
    // The bus starts idle with both lines released.
    initial
    begin
        sclLine = 1'b1;
        sdaDrive = 1'b1;
    end

    // Waits whole clocks, then steps just past the edge.
    task tick(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask

    // One clock pulse; each phase lasts at least two clocks.
    task pulse(input logic b, output logic r);
        begin
            sdaDrive = b;
            tick(2);
            sclLine = 1'b1;
            tick(2);
            r = sdaLine;
            tick(1);
            sclLine = 1'b0;
            tick(1);
        end
    endtask

    // Start or repeated start.
    task start;
        begin
            sdaDrive = 1'b1;
            tick(2);
            sclLine = 1'b1;
            tick(2);
            sdaDrive = 1'b0;
            tick(2);
            sclLine = 1'b0;
            tick(1);
        end
    endtask

    // Stop leaves the bus idle.
    task stop;
        begin
            sdaDrive = 1'b0;
            tick(2);
            sclLine = 1'b1;
            tick(2);
            sdaDrive = 1'b1;
            tick(3);
        end
    endtask

    // Sends a byte most significant bit first and returns the acknowledge.
    task send(input logic [7:0] v, output logic ack);
        logic r;
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
                pulse(v[i], r);
            pulse(1'b1, r);
            ack = !r;
        end
    endtask

    // Receives a byte; last selects a not-acknowledge.
    task recv(input logic last, output logic [7:0] v);
        logic r;
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
            begin
                pulse(1'b1, r);
                v[i] = r;
            end
            pulse(last, r);
        end
    endtask

    task write_word(input logic [6:0] dev, input logic [7:0] code,
                    input logic [15:0] w, output logic [3:0] acks);
        begin
            start;
            send({dev, 1'b0}, acks[3]);
            send(code, acks[2]);
            send(w[7:0], acks[1]);
            send(w[15:8], acks[0]);
            stop;
        end
    endtask

    // whole word read, low byte first
    task read_word(input logic [7:0] code, output logic [15:0] w, output logic [2:0] acks);
        begin
            start;
            send({`PXS_SLAVE_ADDR, 1'b0}, acks[2]);
            send(code, acks[1]);
            start;
            send({`PXS_SLAVE_ADDR, 1'b1}, acks[0]);
            recv(1'b0, w[7:0]);
            recv(1'b1, w[15:8]);
            stop;
        end
    endtask
endmodule

/* File: test/pxs_sensor_regs_assertions.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Watches the bus, interrupt and configuration ports of the register block.
module pxs_sensor_regs_assertions
(
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // Bus and interrupt pins.
    input wire sclIn,
    input wire sdaOe,
    input wire intOe,
    // Measurement and configuration.
    input wire measValid,
    input wire [15:0] standbyWord,
    input wire [15:0] sampleWord,
    input wire [15:0] forceWord,
    input wire [15:0] autocalWord,
    input wire forceTrig,
    input wire fastSampleReq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // A driven bit stays on the wire for at least three cycles after it starts.
    sequence s_bit_held;
        sdaOe [*3];
    endsequence
    // Pulses last one cycle.
    sequence s_force_end;
        ##1 !forceTrig;
    endsequence
    sequence s_fast_end;
        ##1 !fastSampleReq;
    endsequence

    a_sda_low_phase: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data drive changed while bus clock high");
    a_bit_held: assert property ($rose(sdaOe) |-> s_bit_held)
        else $error("data drive released too early");
    a_int_cause: assert property ($rose(intOe) |-> $past(measValid && !sampleWord[0], 2))
        else $error("interrupt rose without a running measurement");
    a_int_mode: assert property ($rose(intOe) |-> $past(sampleWord[3:2], 2) != 2'h0)
        else $error("interrupt rose while disabled");
    a_int_release: assert property (($fell(intOe) && sampleWord[3:2] != 2'h1) |-> !$past(sclIn))
        else $error("interrupt released outside a bus transfer");
    a_word_commit: assert property
        ($changed({standbyWord, sampleWord, forceWord, autocalWord}) |-> !sclIn)
        else $error("configuration changed while bus clock high");
    a_force_pulse: assert property (forceTrig |-> !sclIn and s_force_end)
        else $error("force trigger pulse wrong");
    a_fast_gate: assert property (fastSampleReq |-> sampleWord[1] and s_fast_end)
        else $error("quick re-measure without smart filter");
endmodule

bind pxs_sensor_regs pxs_sensor_regs_assertions u_chk
(
    .mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaOe(sdaOe), .intOe(intOe),
    .measValid(measValid), .standbyWord(standbyWord), .sampleWord(sampleWord),
    .forceWord(forceWord), .autocalWord(autocalWord), .forceTrig(forceTrig),
    .fastSampleReq(fastSampleReq)
);
